// ---- core/mpc_command_unit.v ----
// command interpreter for motion parameter commands
`timescale 1ns/1ps
`default_nettype none
`include "mpc_map.vh"
module mpc_command_unit #(
    parameter CYCLES_PER_MS = (`MPC_MS_NS / `MPC_CLK_NS),
    parameter [7:0] AXIS_ADDR = 8'h01
) (
    input wire clk,
    input wire resetn,
    input wire cmdValid,
    input wire [7:0] cmdAddr,
    input wire [3:0] cmdOp,
    input wire [31:0] cmdArg,
    input wire verbose,
    input wire [3:0] ctlMode,
    input wire axisIdle,
    input wire [3:0] channelCount,
    input wire [31:0] slewVelocity,
    input wire [31:0] limitDeceleration,
    input wire [31:0] commandedPosition,
    input wire [31:0] actualPosition,
    input wire [31:0] inputPosition,
    input wire [31:0] auxiliaryPosition,
    input wire [31:0] datumPosition,
    input wire [31:0] followingError,
    input wire [31:0] endMoveBand,
    input wire [7:0] readPortIn,
    input wire stopInputActive,
    input wire trackingFault,
    input wire stallFault,
    input wire timeoutFault,
    input wire userAbort,
    input wire profileDone,
    input wire jogActive,
    input wire jogFastActive,
    input wire jogNormalSpeed,
    output reg rspValid,
    output reg [7:0] rspAddr,
    output reg [2:0] rspCode,
    output reg rspVerbose,
    output reg [3:0] rspOp,
    output reg [31:0] rspWord0,
    output reg [31:0] rspWord1,
    output reg [31:0] rspWord2,
    output reg [31:0] rspWord3,
    output reg [31:0] rspWord4,
    output reg trackingAbort_r,
    output reg stallAbort_r,
    output reg timeoutAbort_r,
    output reg userAbort_r,
    output reg driveEnable_r,
    output reg loopReset_r,
    output reg loadCommanded_r,
    output reg [31:0] commandedLoad_r,
    output reg [31:0] accelRate_r,
    output reg [31:0] decelRate_r,
    output reg [31:0] creepSpeed_r,
    output reg [31:0] dwellTime_r,
    output reg [31:0] fastJogSpeed_r,
    output reg [31:0] jogSpeed_r,
    output reg moveComplete_r,
    output reg correctMove_r,
    output reg settling_r
);
    reg rstSync1_r;
    reg rstn_r;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstSync1_r <= 1'b0;
            rstn_r <= 1'b0;
        end else begin
            rstSync1_r <= 1'b1;
            rstn_r <= rstSync1_r;
        end
    end

    function inRange;
        input [31:0] v;
        input [31:0] lo;
        input [31:0] hi;
        begin
            inRange = (v >= lo) && (v <= hi);
        end
    endfunction

    function [31:0] absVal;
        input [31:0] v;
        begin
            absVal = v[31] ? (32'h0 - v) : v;
        end
    endfunction

    wire stepper = (ctlMode != `MPC_MODE_SERVO);
    wire [31:0] creepMax = stepper ? `MPC_CREEP_STEP_MAX : `MPC_CREEP_SERVO_MAX;
    wire inBand = absVal(followingError) < endMoveBand;
    wire anyAbort = trackingAbort_r | stallAbort_r | timeoutAbort_r | userAbort_r;
    wire mine = cmdValid && (cmdAddr == AXIS_ADDR);

    wire setDone;
    wire setCorrect;
    wire setBusy;
    mpc_settle #(.CYCLES_PER_MS(CYCLES_PER_MS)) mpc_settle_inst (
        .clk(clk),
        .rstn(rstn_r),
        .ctlMode(ctlMode),
        .dwellMs(dwellTime_r),
        .profileDone(profileDone),
        .inBand(inBand),
        .moveComplete(setDone),
        .correctMove(setCorrect),
        .busy(setBusy)
    );

    always @(posedge clk or negedge rstn_r) begin
        if (!rstn_r) begin
            rspValid <= 1'b0;
            rspAddr <= 8'h00;
            rspCode <= `MPC_RSP_OK;
            rspVerbose <= 1'b0;
            rspOp <= `MPC_OP_NONE;
            rspWord0 <= 32'h0;
            rspWord1 <= 32'h0;
            rspWord2 <= 32'h0;
            rspWord3 <= 32'h0;
            rspWord4 <= 32'h0;
            trackingAbort_r <= 1'b0;
            stallAbort_r <= 1'b0;
            timeoutAbort_r <= 1'b0;
            userAbort_r <= 1'b0;
            driveEnable_r <= 1'b1;
            loopReset_r <= 1'b0;
            loadCommanded_r <= 1'b0;
            commandedLoad_r <= 32'h0;
            accelRate_r <= `MPC_ACCEL_DEF;
            decelRate_r <= `MPC_DECEL_DEF;
            creepSpeed_r <= `MPC_CREEP_DEF;
            dwellTime_r <= `MPC_DWELL_DEF;
            fastJogSpeed_r <= `MPC_FJOG_DEF;
            jogSpeed_r <= 32'h0;
            moveComplete_r <= 1'b0;
            correctMove_r <= 1'b0;
            settling_r <= 1'b0;
        end else begin
            rspValid <= 1'b0;
            loopReset_r <= 1'b0;
            loadCommanded_r <= 1'b0;
            moveComplete_r <= setDone;
            correctMove_r <= setCorrect;
            settling_r <= setBusy;
            // jog speed picks fast value when both inputs active
            jogSpeed_r <= !jogActive ? 32'h0 :
                (jogFastActive ? fastJogSpeed_r : jogNormalSpeed ? creepSpeed_r : 32'h0);
            // fault events latch; on the abort flags set wins over a same-cycle clear, on driveEnable_r the clear wins
            if (trackingFault) trackingAbort_r <= 1'b1;
            if (stallFault) stallAbort_r <= 1'b1;
            if (timeoutFault) timeoutAbort_r <= 1'b1;
            if (userAbort) userAbort_r <= 1'b1;
            if (trackingFault | stallFault | timeoutFault | userAbort | stopInputActive)
                driveEnable_r <= 1'b0;
            if (mine) begin
                rspValid <= 1'b1;
                rspAddr <= AXIS_ADDR;
                rspVerbose <= verbose;
                rspOp <= cmdOp;
                rspCode <= `MPC_RSP_OK;
                rspWord0 <= 32'h0;
                rspWord1 <= 32'h0;
                rspWord2 <= 32'h0;
                rspWord3 <= 32'h0;
                rspWord4 <= 32'h0;
                case (cmdOp)
                `MPC_OP_QCHAN: begin
                    rspCode <= `MPC_RSP_DATA;
                    rspWord0 <= {28'h0, channelCount};
                end
                `MPC_OP_QPOS: begin
                    rspCode <= `MPC_RSP_DATA;
                    rspWord0 <= commandedPosition;
                    rspWord1 <= actualPosition;
                    rspWord2 <= inputPosition;
                    rspWord3 <= auxiliaryPosition;
                    rspWord4 <= datumPosition;
                end
                `MPC_OP_QSPD: begin
                    rspCode <= `MPC_RSP_DATA;
                    rspWord0 <= slewVelocity;
                    rspWord1 <= creepSpeed_r;
                    rspWord2 <= accelRate_r;
                    rspWord3 <= decelRate_r;
                    rspWord4 <= limitDeceleration;
                end
                `MPC_OP_RPORT: begin
                    // bit 7 is input 8, sent first; open reads low
                    rspCode <= `MPC_RSP_DATA;
                    rspWord0 <= {24'h0, readPortIn};
                end
                `MPC_OP_CLRAB: begin
                    if (stopInputActive) begin
                        rspCode <= `MPC_RSP_INAB;
                    end else begin
                        rspCode <= anyAbort ? `MPC_RSP_RESET : `MPC_RSP_NOTAB;
                        trackingAbort_r <= trackingFault;
                        stallAbort_r <= stallFault;
                        timeoutAbort_r <= timeoutFault;
                        userAbort_r <= userAbort;
                        driveEnable_r <= 1'b1;
                        loopReset_r <= 1'b1;
                        if (ctlMode != `MPC_MODE_OLSTEP) begin
                            loadCommanded_r <= 1'b1;
                            commandedLoad_r <= actualPosition;
                        end
                    end
                end
                `MPC_OP_ACCEL: begin
                    if (!axisIdle) rspCode <= `MPC_RSP_BUSY;
                    else if (inRange(cmdArg, `MPC_MIN_ARG, `MPC_ACCEL_MAX))
                        accelRate_r <= cmdArg;
                    else rspCode <= `MPC_RSP_RANGE;
                end
                `MPC_OP_DECEL: begin
                    if (!axisIdle) rspCode <= `MPC_RSP_BUSY;
                    else if (inRange(cmdArg, `MPC_MIN_ARG, `MPC_DECEL_MAX))
                        decelRate_r <= cmdArg;
                    else rspCode <= `MPC_RSP_RANGE;
                end
                `MPC_OP_CREEP: begin
                    // creep feeds final, datum and stepper base speeds
                    if (!axisIdle) rspCode <= `MPC_RSP_BUSY;
                    else if (inRange(cmdArg, `MPC_MIN_ARG, creepMax) && cmdArg <= slewVelocity)
                        creepSpeed_r <= cmdArg;
                    else rspCode <= `MPC_RSP_RANGE;
                end
                `MPC_OP_DWELL: begin
                    if (!axisIdle) rspCode <= `MPC_RSP_BUSY;
                    else if (cmdArg <= `MPC_DWELL_MAX)
                        dwellTime_r <= cmdArg;
                    else rspCode <= `MPC_RSP_RANGE;
                end
                `MPC_OP_FJOG: begin
                    if (!axisIdle) rspCode <= `MPC_RSP_BUSY;
                    else if (inRange(cmdArg, `MPC_MIN_ARG, `MPC_FJOG_MAX))
                        fastJogSpeed_r <= cmdArg;
                    else rspCode <= `MPC_RSP_RANGE;
                end
                default: rspValid <= 1'b0;
                endcase
            end
        end
    end
endmodule // mpc_command_unit
`default_nettype wire

// ---- core/mpc_settle.v ----
// end-of-move settling timer for all control modes
`timescale 1ns/1ps
`default_nettype none
`include "mpc_map.vh"
module mpc_settle #(
    parameter CYCLES_PER_MS = (`MPC_MS_NS / `MPC_CLK_NS)
) (
    input wire clk,
    input wire rstn,
    input wire [3:0] ctlMode,
    input wire [31:0] dwellMs,
    input wire profileDone,
    input wire inBand,
    output reg moveComplete,
    output reg correctMove,
    output reg busy
);
    localparam S_IDLE = 3'b001;
    localparam S_WAIT = 3'b010;
    localparam S_DONE = 3'b100;
    reg [2:0] state_r;
    reg [31:0] msCnt_r;
    reg [31:0] tickCnt_r;
    wire windowed = (ctlMode == `MPC_MODE_SERVO) || (ctlMode == `MPC_MODE_EXSTEP);
    wire timeUp = (msCnt_r >= dwellMs);
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= S_IDLE;
            msCnt_r <= 32'h0;
            tickCnt_r <= 32'h0;
            moveComplete <= 1'b0;
            correctMove <= 1'b0;
            busy <= 1'b0;
        end else begin
            moveComplete <= 1'b0;
            correctMove <= 1'b0;
            case (state_r)
            S_IDLE: begin
                msCnt_r <= 32'h0;
                tickCnt_r <= 32'h0;
                if (profileDone) begin
                    state_r <= S_WAIT;
                    busy <= 1'b1;
                end
            end
            S_WAIT: begin
                if (windowed && !inBand) begin
                    // excursion restarts settling
                    msCnt_r <= 32'h0;
                    tickCnt_r <= 32'h0;
                end else if (timeUp) begin
                    state_r <= S_DONE;
                end else if (tickCnt_r == CYCLES_PER_MS - 1) begin
                    tickCnt_r <= 32'h0;
                    msCnt_r <= msCnt_r + 32'h1;
                end else begin
                    tickCnt_r <= tickCnt_r + 32'h1;
                end
            end
            S_DONE: begin
                state_r <= S_IDLE;
                busy <= 1'b0;
                case (ctlMode)
                `MPC_MODE_CKSTEP: moveComplete <= inBand;
                `MPC_MODE_CLSTEP: begin
                    moveComplete <= inBand;
                    correctMove <= !inBand;
                end
                default: moveComplete <= 1'b1;
                endcase
            end
            default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule // mpc_settle
`default_nettype wire

// ---- inc/mpc_map.vh ----
// constants for the motion parameter command block
`ifndef MPC_MAP_VH
`define MPC_MAP_VH
// command codes
`define MPC_OP_NONE 4'h0
`define MPC_OP_QCHAN 4'h1
`define MPC_OP_QPOS 4'h2
`define MPC_OP_QSPD 4'h3
`define MPC_OP_RPORT 4'h4
`define MPC_OP_CLRAB 4'h5
`define MPC_OP_ACCEL 4'h6
`define MPC_OP_CREEP 4'h7
`define MPC_OP_DECEL 4'h8
`define MPC_OP_DWELL 4'h9
`define MPC_OP_FJOG 4'ha
// reply codes
`define MPC_RSP_OK 3'h0
`define MPC_RSP_RANGE 3'h1
`define MPC_RSP_RESET 3'h2
`define MPC_RSP_NOTAB 3'h3
`define MPC_RSP_INAB 3'h4
`define MPC_RSP_DATA 3'h5
`define MPC_RSP_BUSY 3'h6
// control modes
`define MPC_MODE_SERVO 4'h1
`define MPC_MODE_OLSTEP 4'hb
`define MPC_MODE_CKSTEP 4'hc
`define MPC_MODE_EXSTEP 4'hd
`define MPC_MODE_CLSTEP 4'he
// limits and defaults
`define MPC_ACCEL_MAX 32'h001e8480
`define MPC_ACCEL_DEF 32'h000007d0
`define MPC_DECEL_MAX 32'h001e8480
`define MPC_DECEL_DEF 32'h00000bb8
`define MPC_CREEP_SERVO_MAX 32'h00061a80
`define MPC_CREEP_STEP_MAX 32'h00000320
`define MPC_CREEP_DEF 32'h00000320
`define MPC_DWELL_MAX 32'h00004e20
`define MPC_DWELL_DEF 32'h00000064
`define MPC_FJOG_MAX 32'h00030d40
`define MPC_FJOG_DEF 32'h000001f4
`define MPC_MIN_ARG 32'h00000001
// timing and address digits
`define MPC_CLK_MHZ 250
`define MPC_MS_NS 1000000
`define MPC_CLK_NS 4
`define MPC_ADDR_DIGITS 2
`endif

// ---- tb/mpc_cmd_properties.sv ----
// concurrent checks on the command unit ports
`timescale 1ns/1ps
`default_nettype none
`include "mpc_map.vh"
module mpc_cmd_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic cmdValid,
    input wire logic [7:0] cmdAddr,
    input wire logic [3:0] cmdOp,
    input wire logic [31:0] cmdArg,
    input wire logic [3:0] ctlMode,
    input wire logic axisIdle,
    input wire logic [31:0] slewVelocity,
    input wire logic [7:0] readPortIn,
    input wire logic stopInputActive,
    input wire logic rspValid,
    input wire logic [7:0] rspAddr,
    input wire logic [2:0] rspCode,
    input wire logic [31:0] rspWord0,
    input wire logic userAbort_r,
    input wire logic loadCommanded_r,
    input wire logic [31:0] accelRate_r,
    input wire logic moveComplete_r,
    input wire logic correctMove_r,
    input wire logic settling_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire logic take = cmdValid && (cmdAddr == 8'h01);
    wire logic setA = take && (cmdOp == `MPC_OP_ACCEL) && axisIdle;
    wire logic clr = take && (cmdOp == `MPC_OP_CLRAB);
    reply_on_cmd_a:
        assert property (take && cmdOp != 4'h0 && cmdOp <= `MPC_OP_FJOG |=> rspValid && rspAddr == 8'h01)
        else $error("addressed command got no reply");
    foreign_addr_a:
        assert property (cmdValid && cmdAddr != 8'h01 |=> !rspValid)
        else $error("reply to another axis address");
    accel_range_a:
        assert property (setA && (cmdArg == 0 || cmdArg > `MPC_ACCEL_MAX)
            |=> rspCode == `MPC_RSP_RANGE && $stable(accelRate_r))
        else $error("bad acceleration not refused");
    accel_take_a:
        assert property (setA && cmdArg != 0 && cmdArg <= `MPC_ACCEL_MAX
            |=> rspCode == `MPC_RSP_OK && accelRate_r == $past(cmdArg))
        else $error("acceleration not taken");
    port_sample_a:
        assert property (take && cmdOp == `MPC_OP_RPORT |=> rspWord0[7:0] == $past(readPortIn))
        else $error("port snapshot wrong");
    stop_refuse_a:
        assert property (clr && stopInputActive |=> rspCode == `MPC_RSP_INAB && !loadCommanded_r)
        else $error("clear taken while stop active");
    clear_load_a:
        assert property (clr && !stopInputActive && userAbort_r
            |=> loadCommanded_r == ($past(ctlMode) != `MPC_MODE_OLSTEP))
        else $error("commanded load wrong on clear");
    creep_slew_a:
        assert property (take && cmdOp == `MPC_OP_CREEP && axisIdle && cmdArg > slewVelocity
            |=> rspCode == `MPC_RSP_RANGE)
        else $error("creep above slew accepted");
    settle_first_a:
        assert property ($rose(moveComplete_r) |-> $past(settling_r))
        else $error("move complete without settling");
    cover property (rspValid && rspCode == `MPC_RSP_INAB);
    cover property (moveComplete_r);
    cover property (correctMove_r);
endmodule // mpc_cmd_checker
bind mpc_command_unit mpc_cmd_checker mpc_cmd_checker_inst (
    .clk(clk), .resetn(resetn), .cmdValid(cmdValid), .cmdAddr(cmdAddr), .cmdOp(cmdOp),
    .cmdArg(cmdArg), .ctlMode(ctlMode), .axisIdle(axisIdle), .slewVelocity(slewVelocity),
    .readPortIn(readPortIn), .stopInputActive(stopInputActive), .rspValid(rspValid),
    .rspAddr(rspAddr), .rspCode(rspCode), .rspWord0(rspWord0), .userAbort_r(userAbort_r),
    .loadCommanded_r(loadCommanded_r), .accelRate_r(accelRate_r),
    .moveComplete_r(moveComplete_r), .correctMove_r(correctMove_r), .settling_r(settling_r)
);
`default_nettype wire

// ---- tb/mpc_host_model.sv ----
// host side model that issues addressed commands
`timescale 1ns/1ps
`default_nettype none
module mpc_host_model (
    input wire logic clk,
    output logic cmdValid,
    output logic [7:0] cmdAddr,
    output logic [3:0] cmdOp,
    output logic [31:0] cmdArg
);
    initial begin
        cmdValid = 1'b0;
        cmdAddr = 8'h00;
        cmdOp = 4'h0;
        cmdArg = 32'h0;
    end
    // one command per call, sampled at the next edge
    task automatic send(input logic [7:0] addr, input logic [3:0] op, input logic [31:0] arg);
        @(posedge clk);
        cmdValid <= 1'b1;
        cmdAddr <= addr;
        cmdOp <= op;
        cmdArg <= arg;
        @(posedge clk);
        cmdValid <= 1'b0;
        cmdAddr <= ~addr;
        cmdArg <= ~arg;
        #1;
    endtask
endmodule // mpc_host_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the motion parameter command unit
`timescale 1ns/1ps
`default_nettype none
`include "mpc_map.vh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] ctlMode = `MPC_MODE_SERVO;
    logic axisIdle = 1'b1;
    logic [3:0] chans = 4'h7;
    logic [31:0] slewVelocity = 32'd1000;
    logic [31:0] posVal = 32'h100;
    logic [31:0] followingError = 32'h0;
    logic [7:0] readPortIn = 8'h11;
    logic stopInputActive = 1'b0;
    logic userAbort = 1'b0;
    logic profileDone = 1'b0;
    logic jogActive = 1'b0;
    logic jogFastActive = 1'b0;
    int n_mismatch = 0;
    int total_checks = 0;
    int n;
    wire logic cmdValid, rspValid, userAbort_r, driveEnable_r, loadCommanded_r;
    wire logic moveComplete_r, correctMove_r;
    wire logic [7:0] cmdAddr, rspAddr;
    wire logic [3:0] cmdOp;
    wire logic [2:0] rspCode;
    wire logic [31:0] cmdArg, rspWord0, rspWord1, rspWord2, rspWord3, rspWord4, commandedLoad_r;
    wire logic [31:0] accelRate_r, decelRate_r, creepSpeed_r, dwellTime_r, fastJogSpeed_r;
    wire logic [31:0] jogSpeed_r;
    wire logic rspVerbose, loopReset_r, settling_r, trackingAbort_r, stallAbort_r, timeoutAbort_r;
    wire logic [3:0] rspOp;
    logic verbose = 1'b0;
    logic [3:0] sOp [4] = '{`MPC_OP_ACCEL, `MPC_OP_DECEL, `MPC_OP_DWELL, `MPC_OP_FJOG};
    logic [31:0] sMax [4] = '{`MPC_ACCEL_MAX, `MPC_DECEL_MAX, `MPC_DWELL_MAX, `MPC_FJOG_MAX};
    always #2 clk = ~clk;
    mpc_host_model mpc_host_model_inst (.clk(clk), .cmdValid(cmdValid), .cmdAddr(cmdAddr),
        .cmdOp(cmdOp), .cmdArg(cmdArg));
    mpc_command_unit #(.CYCLES_PER_MS(4)) mpc_command_unit_inst (
        .clk(clk), .resetn(resetn), .cmdValid(cmdValid), .cmdAddr(cmdAddr), .cmdOp(cmdOp),
        .cmdArg(cmdArg), .verbose(verbose), .ctlMode(ctlMode), .axisIdle(axisIdle),
        .channelCount(chans), .slewVelocity(slewVelocity), .limitDeceleration(posVal + 32'd5),
        .commandedPosition(posVal), .actualPosition(posVal + 32'd1),
        .inputPosition(posVal + 32'd2), .auxiliaryPosition(posVal + 32'd3),
        .datumPosition(posVal + 32'd4), .followingError(followingError),
        .endMoveBand(32'h4), .readPortIn(readPortIn), .stopInputActive(stopInputActive),
        .trackingFault(userAbort), .stallFault(userAbort), .timeoutFault(userAbort),
        .userAbort(userAbort), .profileDone(profileDone), .jogActive(jogActive),
        .jogFastActive(jogFastActive), .jogNormalSpeed(1'b0), .rspValid(rspValid),
        .rspAddr(rspAddr), .rspCode(rspCode), .rspVerbose(rspVerbose), .rspOp(rspOp),
        .rspWord0(rspWord0), .rspWord1(rspWord1), .rspWord2(rspWord2), .rspWord3(rspWord3),
        .rspWord4(rspWord4), .trackingAbort_r(trackingAbort_r), .stallAbort_r(stallAbort_r),
        .timeoutAbort_r(timeoutAbort_r), .userAbort_r(userAbort_r),
        .driveEnable_r(driveEnable_r), .loopReset_r(loopReset_r),
        .loadCommanded_r(loadCommanded_r),
        .commandedLoad_r(commandedLoad_r), .accelRate_r(accelRate_r),
        .decelRate_r(decelRate_r), .creepSpeed_r(creepSpeed_r), .dwellTime_r(dwellTime_r),
        .fastJogSpeed_r(fastJogSpeed_r), .jogSpeed_r(jogSpeed_r),
        .moveComplete_r(moveComplete_r), .correctMove_r(correctMove_r), .settling_r(settling_r));
    function automatic logic [31:0] cur(input int i);
        case (i)
            0: return accelRate_r;
            1: return decelRate_r;
            2: return dwellTime_r;
            default: return fastJogSpeed_r;
        endcase
    endfunction
    task automatic cmd(input logic [3:0] op, input logic [31:0] arg, input logic [2:0] code);
        mpc_host_model_inst.send(8'h01, op, arg);
        `CHK("reply valid", 1'b1, rspValid)
        `CHK("reply addr", 8'h01, rspAddr)
        `CHK("reply code", code, rspCode)
        `CHK("reply op", op, rspOp)
        `CHK("reply verbose", verbose, rspVerbose)
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // pulse end of profile, count cycles to completion or correction
    task automatic settle();
        @(posedge clk) profileDone <= 1'b1;
        @(posedge clk) profileDone <= 1'b0;
        for (n = 1; n < 60 && moveComplete_r !== 1'b1 && correctMove_r !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        if (n >= 60) begin
            n_mismatch++;
            complete_run();
        end
    endtask
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        `CHK("accel def", `MPC_ACCEL_DEF, accelRate_r)
        `CHK("decel def", `MPC_DECEL_DEF, decelRate_r)
        `CHK("creep def", `MPC_CREEP_DEF, creepSpeed_r)
        `CHK("dwell def", `MPC_DWELL_DEF, dwellTime_r)
        `CHK("fjog def", `MPC_FJOG_DEF, fastJogSpeed_r)
        cmd(`MPC_OP_QCHAN, 32'h0, `MPC_RSP_DATA);
        `CHK("channels", 32'd7, rspWord0)
        mpc_host_model_inst.send(8'h02, `MPC_OP_QCHAN, 32'h0);
        `CHK("foreign reply", 1'b0, rspValid)
        for (int i = 0; i < 4; i++) begin
            cmd(sOp[i], sMax[i], `MPC_RSP_OK);
            `CHK("set max", sMax[i], cur(i))
            cmd(sOp[i], sMax[i] + 32'd1, `MPC_RSP_RANGE);
            `CHK("kept", sMax[i], cur(i))
            cmd(sOp[i], 32'd0, (i == 2) ? `MPC_RSP_OK : `MPC_RSP_RANGE);
        end
        axisIdle <= 1'b0;
        cmd(`MPC_OP_ACCEL, 32'd5, `MPC_RSP_BUSY);
        `CHK("accel busy", `MPC_ACCEL_MAX, accelRate_r)
        axisIdle <= 1'b1;
        cmd(`MPC_OP_CREEP, 32'd1001, `MPC_RSP_RANGE);
        cmd(`MPC_OP_CREEP, 32'd700, `MPC_RSP_OK);
        ctlMode <= `MPC_MODE_CLSTEP;
        slewVelocity <= 32'd5000;
        cmd(`MPC_OP_CREEP, 32'd801, `MPC_RSP_RANGE);
        `CHK("creep kept", 32'd700, creepSpeed_r)
        cmd(`MPC_OP_QPOS, 32'h0, `MPC_RSP_DATA);
        `CHK("cmd pos", posVal, rspWord0)
        `CHK("datum pos", posVal + 32'd4, rspWord4)
        cmd(`MPC_OP_QSPD, 32'h0, `MPC_RSP_DATA);
        `CHK("slew", 32'd5000, rspWord0)
        `CHK("creep", 32'd700, rspWord1)
        `CHK("accel", `MPC_ACCEL_MAX, rspWord2)
        `CHK("limdecel", posVal + 32'd5, rspWord4)
        verbose <= 1'b1;
        cmd(`MPC_OP_RPORT, 32'h0, `MPC_RSP_DATA);
        `CHK("port", 8'h11, rspWord0[7:0])
        readPortIn <= 8'h00;
        cmd(`MPC_OP_RPORT, 32'h0, `MPC_RSP_DATA);
        `CHK("port open", 8'h00, rspWord0[7:0])
        userAbort <= 1'b1;
        stopInputActive <= 1'b1;
        @(posedge clk) userAbort <= 1'b0;
        cmd(`MPC_OP_CLRAB, 32'h0, `MPC_RSP_INAB);
        `CHK("abort held", 1'b1, userAbort_r)
        `CHK("aborts held", 3'h7, {trackingAbort_r, stallAbort_r, timeoutAbort_r})
        `CHK("drive off", 1'b0, driveEnable_r)
        stopInputActive <= 1'b0;
        posVal <= 32'h2000;
        cmd(`MPC_OP_CLRAB, 32'h0, `MPC_RSP_RESET);
        `CHK("abort cleared", 1'b0, userAbort_r)
        `CHK("aborts cleared", 3'h0, {trackingAbort_r, stallAbort_r, timeoutAbort_r})
        `CHK("loop reset", 1'b1, loopReset_r)
        `CHK("drive enable", 1'b1, driveEnable_r)
        `CHK("load", 1'b1, loadCommanded_r)
        `CHK("load value", 32'h2001, commandedLoad_r)
        cmd(`MPC_OP_CLRAB, 32'h0, `MPC_RSP_NOTAB);
        jogActive <= 1'b1;
        jogFastActive <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        `CHK("jog speed", `MPC_FJOG_MAX, jogSpeed_r)
        ctlMode <= `MPC_MODE_SERVO;
        cmd(`MPC_OP_DWELL, 32'd1, `MPC_RSP_OK);
        fork
            settle();
            begin
                repeat (4) @(posedge clk);
                followingError <= 32'd100;
                @(posedge clk) followingError <= 32'd0;
                #1;
                `CHK("settling", 1'b1, settling_r)
            end
        join
        // without the restart completion would be seen at n of 8
        `CHK("restart", 1'b1, n >= 10)
        `CHK("servo done", 1'b1, moveComplete_r)
        ctlMode <= `MPC_MODE_CLSTEP;
        followingError <= 32'd100;
        settle();
        `CHK("correction", 1'b1, correctMove_r)
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
